/* rtl/post_params.svh */
`ifndef POST_PARAMS_SVH
`define POST_PARAMS_SVH
// strap code values
`define POST_CODE_SERIAL 2'h0
`define POST_CODE_PARALLEL 2'h1
`define POST_CODE_RESERVED 2'h2
`define POST_CODE_BYPASS 2'h3
// strap bit positions within the pin pair
`define POST_STRAP_HI_BIT 1
`define POST_STRAP_LO_BIT 0
// nominal fused run time
`define POST_FUSED_RUN_MS 20
`endif

/* rtl/post_pkg.sv */
package post_pkg;
  typedef enum logic [2:0] {
    POST_IDLE = 3'b000,
    POST_SAMPLE = 3'b001,
    POST_SEC = 3'b010,
    POST_MCU = 3'b011,
    POST_PAR = 3'b100,
    POST_MEM = 3'b101,
    POST_DONE = 3'b110
  } post_state_t;
endpackage : post_pkg

/* rtl/post_sync.sv */
`timescale 1ns/1ps
module post_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s1_next;
  logic [WIDTH-1:0] s2_next;

  always_comb
  begin
    s1_next = ce ? d : s1_reg;
    s2_next = ce ? s1_reg : s2_reg;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
    end
    else
    begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
    end
  end

  assign q = s2_reg;
endmodule : post_sync

/* rtl/post_select.sv */
`timescale 1ns/1ps
`include "post_params.svh"
module post_select #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [1:0] boot_strap_pins,
  input wire logic fuse_override,
  input wire logic fuse_post_enable,
  output logic sec_test_start,
  input wire logic sec_test_done,
  output logic mcu_test_start,
  input wire logic mcu_test_done,
  output logic mem_test_start,
  input wire logic mem_test_done,
  output logic boot_release,
  output logic [1:0] post_mode,
  output logic strap_reserved
);
  import post_pkg::*;

  // ****************************************************************
  // checks
  // ****************************************************************
  if (SYNC_STAGES != 2)
  begin : g_bad_stages
    $error("only two synchroniser stages are served");
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0] strap_sync;
  logic [1:0] fuse_sync;

  post_sync #(.WIDTH(2)) u_strap_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .d(boot_strap_pins),
    .q(strap_sync)
  );

  post_sync #(.WIDTH(2)) u_fuse_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .d({fuse_override, fuse_post_enable}),
    .q(fuse_sync)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************
  post_state_t state_reg;
  post_state_t state_next;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic sec_done_reg;
  logic sec_done_next;
  logic mcu_done_reg;
  logic mcu_done_next;
  logic sec_start_reg;
  logic sec_start_next;
  logic mcu_start_reg;
  logic mcu_start_next;
  logic mem_start_reg;
  logic mem_start_next;
  logic release_reg;
  logic release_next;
  logic reserved_reg;
  logic reserved_next;
  logic settle_reg;
  logic settle_next;
  logic [1:0] sel_code;

  always_comb
  begin
    // fuses win over the pins when override is programmed
    if (fuse_sync[1])
      sel_code = fuse_sync[0] ? `POST_CODE_PARALLEL : `POST_CODE_BYPASS;
    else
      sel_code = {strap_sync[`POST_STRAP_HI_BIT], strap_sync[`POST_STRAP_LO_BIT]};
  end

  always_comb
  begin
    state_next = state_reg;
    mode_next = mode_reg;
    sec_done_next = sec_done_reg;
    mcu_done_next = mcu_done_reg;
    sec_start_next = 1'b0;
    mcu_start_next = 1'b0;
    mem_start_next = 1'b0;
    release_next = release_reg;
    reserved_next = reserved_reg;
    settle_next = settle_reg;
    case (state_reg)
      POST_IDLE:
      begin
        // extra cycle so the second stage holds the pins
        settle_next = 1'b1;
        if (settle_reg)
          state_next = POST_SAMPLE;
      end
      POST_SAMPLE:
      begin
        mode_next = sel_code;
        sec_done_next = 1'b0;
        mcu_done_next = 1'b0;
        case (sel_code)
          `POST_CODE_SERIAL:
          begin
            state_next = POST_SEC;
            sec_start_next = 1'b1;
          end
          `POST_CODE_PARALLEL:
          begin
            state_next = POST_PAR;
            sec_start_next = 1'b1;
            mcu_start_next = 1'b1;
          end
          `POST_CODE_RESERVED:
          begin
            // reserved code treated as bypass, flagged
            reserved_next = 1'b1;
            state_next = POST_DONE;
            release_next = 1'b1;
          end
          default:
          begin
            state_next = POST_DONE;
            release_next = 1'b1;
          end
        endcase
      end
      POST_SEC:
        if (sec_test_done)
        begin
          state_next = POST_MCU;
          mcu_start_next = 1'b1;
        end
      POST_MCU:
        if (mcu_test_done)
        begin
          state_next = POST_MEM;
          mem_start_next = 1'b1;
        end
      POST_PAR:
      begin
        if (sec_test_done)
          sec_done_next = 1'b1;
        if (mcu_test_done)
          mcu_done_next = 1'b1;
        if ((sec_done_reg || sec_test_done) && (mcu_done_reg || mcu_test_done))
        begin
          state_next = POST_MEM;
          mem_start_next = 1'b1;
        end
      end
      POST_MEM:
        if (mem_test_done)
        begin
          state_next = POST_DONE;
          release_next = 1'b1;
        end
      POST_DONE:
        state_next = POST_DONE;
      default:
        state_next = POST_IDLE;
    endcase
    if (!ce)
    begin
      state_next = state_reg;
      mode_next = mode_reg;
      sec_done_next = sec_done_reg;
      mcu_done_next = mcu_done_reg;
      sec_start_next = sec_start_reg;
      mcu_start_next = mcu_start_reg;
      mem_start_next = mem_start_reg;
      release_next = release_reg;
      reserved_next = reserved_reg;
      settle_next = settle_reg;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= POST_IDLE;
      mode_reg <= `POST_CODE_BYPASS;
      sec_done_reg <= 1'b0;
      mcu_done_reg <= 1'b0;
      sec_start_reg <= 1'b0;
      mcu_start_reg <= 1'b0;
      mem_start_reg <= 1'b0;
      release_reg <= 1'b0;
      reserved_reg <= 1'b0;
      settle_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      sec_done_reg <= sec_done_next;
      mcu_done_reg <= mcu_done_next;
      sec_start_reg <= sec_start_next;
      mcu_start_reg <= mcu_start_next;
      mem_start_reg <= mem_start_next;
      release_reg <= release_next;
      reserved_reg <= reserved_next;
      settle_reg <= settle_next;
    end
  end

  assign sec_test_start = sec_start_reg;
  assign mcu_test_start = mcu_start_reg;
  assign mem_test_start = mem_start_reg;
  assign boot_release = release_reg;
  assign post_mode = mode_reg;
  assign strap_reserved = reserved_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence serial_step_s;
    ce && state_reg == POST_SEC && sec_test_done;
  endsequence

  sequence par_join_s;
    ce && state_reg == POST_PAR && (sec_done_reg || sec_test_done) && (mcu_done_reg || mcu_test_done);
  endsequence

  serial_order_a: assert property (serial_step_s |=> mcu_test_start && !mem_test_start)
    else $error("mcu test not started after security test");
  mem_after_mcu_a: assert property (ce && state_reg == POST_MCU && mcu_test_done |=> mem_test_start)
    else $error("memory test not started after mcu test");
  par_start_a: assert property (ce && state_reg == POST_SAMPLE && sel_code == `POST_CODE_PARALLEL
    |=> sec_test_start && mcu_test_start)
    else $error("parallel tests not started together");
  par_join_a: assert property (par_join_s |=> mem_test_start)
    else $error("memory test not started after both logic tests");
  mem_guard_a: assert property (mem_test_start |-> $past(state_reg) == POST_MCU || $past(state_reg) == POST_PAR)
    else $error("memory test started out of order");
  bypass_a: assert property (ce && state_reg == POST_SAMPLE && sel_code == `POST_CODE_BYPASS
    |=> boot_release && !sec_test_start)
    else $error("bypass did not release boot");
  fuse_sel_a: assert property (ce && state_reg == POST_SAMPLE && fuse_sync[1]
    |=> post_mode == ($past(fuse_sync[0]) ? 2'h1 : 2'h3))
    else $error("fuse override not honoured");
  strap_sel_a: assert property (ce && state_reg == POST_SAMPLE && !fuse_sync[1]
    |=> post_mode == $past(strap_sync))
    else $error("strap pins not used without override");
  release_hold_a: assert property (boot_release |=> boot_release)
    else $error("boot release dropped");
  release_cause_a: assert property ($rose(boot_release) |-> $past(state_reg) == POST_MEM
    || $past(state_reg) == POST_SAMPLE)
    else $error("boot released before test finished");
endmodule : post_select

/* verif/post_board_model.sv */
`timescale 1ns/1ps
// ****************************************
// board straps and self-test engines
// ****************************************
module post_board_model (
  input wire logic clk,
  input wire logic fused,
  input wire logic obey,
  input wire logic [1:0] pick,
  input wire logic [2:0] start,
  input wire logic [11:0] delay,
  output logic [1:0] boot_strap_pins,
  output logic [2:0] done
);
  // obey low lets the bench strap off-recommendation on purpose
  assign boot_strap_pins = obey ? (fused ? 2'h1 : 2'h3) : pick;
  for (genvar i = 0; i < 3; i++)
  begin : g_resp
    initial done[i] = 1'b0;
    always
    begin
      @(posedge clk);
      if (start[i] === 1'b1)
      begin
        repeat (delay[i*4 +: 4]) @(posedge clk);
        #1 done[i] = 1'b1;
        @(posedge clk);
        #1 done[i] = 1'b0;
      end
    end
  end
endmodule : post_board_model

/* verif/testbench.sv */
`timescale 1ns/1ps
// ****************************************
// power-on self-test selection bench
// ****************************************
module testbench;
  import post_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic fov = 1'b0;
  logic fen = 1'b0;
  logic obey = 1'b0;
  logic [1:0] pick = 2'h0;
  logic [11:0] dly = 12'h000;
  logic [1:0] pins;
  logic [2:0] done;
  logic sec_s, mcu_s, mem_s, rel, resv;
  logic [1:0] mode;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_s, n_m, n_k;
  logic [15:0] t_s, t_m, t_k, t_r;
  logic [16:0] tbl [10] = '{17'h00000, 17'h05000, 17'h03000, 17'h06000, 17'h0df0f,
    17'h09123, 17'h0c5a3, 17'h0a000, 17'h18000, 17'h10000};
  logic [31:0] r;

  always #2 clk = ~clk;

  always @(posedge clk)
  begin
    if (sec_s === 1'b1) begin n_s++; if (t_s === 16'hffff) t_s = 16'(cyc); end
    if (mcu_s === 1'b1) begin n_m++; if (t_m === 16'hffff) t_m = 16'(cyc); end
    if (mem_s === 1'b1) begin n_k++; if (t_k === 16'hffff) t_k = 16'(cyc); end
    if (rel === 1'b1 && t_r === 16'hffff) t_r = 16'(cyc);
    cyc++;
  end

  post_select i_dut (.clk(clk), .nrst(nrst), .ce(ce), .boot_strap_pins(pins), .fuse_override(fov),
    .fuse_post_enable(fen), .sec_test_start(sec_s), .sec_test_done(done[0]), .mcu_test_start(mcu_s),
    .mcu_test_done(done[1]), .mem_test_start(mem_s), .mem_test_done(done[2]), .boot_release(rel),
    .post_mode(mode), .strap_reserved(resv));

  post_board_model i_board (.clk(clk), .fused(fov), .obey(obey), .pick(pick),
    .start({mem_s, mcu_s, sec_s}), .delay(dly), .boot_strap_pins(pins), .done(done));

  function automatic logic [1:0] exp_mode(input logic ov, input logic en, input logic [1:0] p);
    return ov ? (en ? 2'h1 : 2'h3) : p;
  endfunction : exp_mode

  function automatic logic [15:0] after_done(input logic [15:0] t, input logic [3:0] d);
    return t + 16'(d) + 16'd2;
  endfunction : after_done

  task automatic final_report();
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic run_case(input logic [4:0] c, input logic [11:0] d, input logic [1:0] st);
    logic [1:0] pe, m;
    logic [15:0] es, em, ek, er, b;
    int i;
    @(posedge clk);
    #1 nrst = 1'b0;
    {obey, fov, fen, pick} = c;
    dly = d;
    // clock enable held low for st cycles after release
    ce = (st == 2'h0);
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    cyc = 0;
    {t_s, t_m, t_k, t_r} = {4{16'hffff}};
    {n_s, n_m, n_k} = {3{0}};
    pe = obey ? (fov ? 2'h1 : 2'h3) : pick;
    m = exp_mode(fov, fen, pe);
    b = 16'd3 + 16'(st);
    es = m[1] ? 16'hffff : b;
    em = m[1] ? 16'hffff : (m == 2'h0 ? after_done(es, d[3:0]) : b);
    ek = m == 2'h0 ? after_done(em, d[7:4]) : after_done(b, d[3:0] > d[7:4] ? d[3:0] : d[7:4]);
    if (m[1])
      ek = 16'hffff;
    er = m[1] ? b : after_done(ek, d[11:8]);
    i = 0;
    while (rel !== 1'b1 && i < 200)
    begin
      @(posedge clk);
      #1 i++;
      if (i == int'(st))
        ce = 1'b1;
      // late strap change must not alter the run
      if (i == 6 && !obey) pick = ~pick;
    end
    if (i >= 200)
    begin
      fails++;
      final_report();
    end
    repeat (4) @(posedge clk);
    #1 cmp("post_mode", 16'(m), 16'(mode));
    cmp("strap_reserved", 16'(!fov && pe == 2'h2), 16'(resv));
    cmp("sec_start_time", es, t_s);
    cmp("mcu_start_time", em, t_m);
    cmp("mem_start_time", ek, t_k);
    cmp("release_time", er, t_r);
    cmp("start_pulses", m[1] ? 16'h0 : 16'h111, {4'h0, 4'(n_s), 4'(n_m), 4'(n_k)});
  endtask : run_case

  initial
  begin
    void'($urandom(65110));
    for (int k = 0; k < 10; k++)
      run_case(tbl[k][16:12], tbl[k][11:0], 2'(k));
    for (int k = 0; k < 12; k++)
    begin
      r = $urandom;
      run_case(r[4:0], r[16:5], r[18:17]);
    end
    final_report();
  end
endmodule : testbench
